// ===== bench/iosd_core_model.sv
// core model issuing io requests
`timescale 1ns/10ps
module iosd_core_model (
	input  wire       clk_sys,   // core clock
	input  wire [7:0] rdata,     // read data
	input  wire       bit_value, // tested bit
	output reg  [6:0] req,       // one line per kind
	output reg  [7:0] addr,      // address or index
	output reg  [7:0] wdata,     // write data
	output reg  [2:0] bsel       // bit number
);
	reg [7:0] got; // last answer
	initial begin
		req = 7'h00;
		addr = 8'h00;
		wdata = 8'h00;
		bsel = 3'h0;
	end
	// kinds: 0 load 1 store 2 in 3 out 4 set 5 clear 6 test
	task op(input [2:0] k, input [7:0] a, input [7:0] d, input [2:0] b);
		begin
			@(posedge clk_sys) #1;
			req = 7'h01 << k;
			addr = a;
			wdata = d; // write data goes out unchanged, all bits
			bsel = b;
			@(posedge clk_sys) #1;
			req = 7'h00;
			addr = ~a; // released lines lose the old value
			wdata = ~d;
			got = (k == 3'h6) ? {7'h00, bit_value} : rdata;
		end
	endtask
endmodule

// ===== bench/iosd_io_space_assertions.sv
// port assertions for the io space decoder
`timescale 1ns/10ps
`include "iosd_defines.vh"
module iosd_io_space_chk (
	input wire       CLK_SYS,   // clock
	input wire       RST_N,     // reset
	input wire       LDST_RD,   // load
	input wire       LDST_WR,   // store
	input wire [7:0] LDST_ADDR, // address
	input wire       PORT_RD,   // port in
	input wire       PORT_WR,   // port out
	input wire [5:0] PORT_IDX,  // port index
	input wire       BIT_TEST,  // bit test
	input wire [4:0] BIT_IDX,   // bit index
	input wire [2:0] BIT_SEL,   // bit number
	input wire [7:0] WDATA,     // write data
	input wire [7:0] RDATA,     // read data
	input wire       RD_VALID,  // read valid
	input wire       BIT_VALUE, // tested bit
	input wire       BIT_VALID, // test valid
	input wire       ADDR_MISS  // miss
);
	wire ls = LDST_RD | LDST_WR;
	wire rq = LDST_RD | (PORT_RD & ~ls);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	sequence st1; LDST_WR && !LDST_RD && LDST_ADDR == `IOSD_ADDR_SCR1; endsequence
	sequence ld1; LDST_RD && !LDST_WR && LDST_ADDR == `IOSD_ADDR_SCR1; endsequence
	sequence out0; PORT_WR && !ls && PORT_IDX == 6'h1e; endsequence
	sequence tst0; BIT_TEST && !ls && !PORT_RD && !PORT_WR && BIT_IDX == 5'h1e; endsequence
	read_answer_a: assert property (rq |=> RD_VALID)
		else $error("read not answered");
	read_cause_a: assert property (RD_VALID |-> $past(LDST_RD) || $past(PORT_RD))
		else $error("stray read valid");
	test_answer_a: assert property (tst0 |=> BIT_VALID)
		else $error("test not answered");
	scr1_back_a: assert property (st1 ##2 ld1 |=> RDATA == $past(WDATA, 3))
		else $error("scratch one lost");
	scr0_bit_a: assert property (out0 ##2 tst0 |=>
		BIT_VALUE == (($past(WDATA, 3) >> $past(BIT_SEL)) & 8'h01)) else $error("bad bit");
	miss_zero_a: assert property (PORT_RD && !ls && PORT_IDX == 6'h00 |=>
		ADDR_MISS && RDATA == 8'h00) else $error("unmapped read");
	ext_reach_a: assert property (LDST_RD && LDST_ADDR == `IOSD_ADDR_FLAGEN |=>
		RD_VALID && !ADDR_MISS) else $error("extended miss");
	rdata_hold_a: assert property (!rq |=> $stable(RDATA))
		else $error("read data moved");
endmodule
bind iosd_io_space iosd_io_space_chk chk_u (.*);

// ===== bench/iosd_io_space_tb.sv
// self-checking bench for the io space decoder
`timescale 1ns/10ps
`include "iosd_defines.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module iosd_io_space_tb;
	reg        clk_sys = 1'b0; // core clock
	reg        rst_n = 1'b0;   // reset, active low
	reg  [7:0] ev = 8'h00;     // status events
	wire [6:0] req;            // request lines
	wire [7:0] addr;           // address or index
	wire [7:0] wdata;          // write data
	wire [2:0] bsel;           // bit number
	wire [7:0] rdata;          // read data
	wire       bit_value;      // tested bit
	int        n_fail = 0;     // mismatches
	int        comparisons = 0; // compares
	reg  [7:0] v, m, f;        // random, enable, flags
	int        i;              // loop index
	iosd_io_space dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .LDST_RD(req[0]), .LDST_WR(req[1]),
		.LDST_ADDR(addr), .PORT_RD(req[2]), .PORT_WR(req[3]), .PORT_IDX(addr[5:0]),
		.BIT_SET(req[4]), .BIT_CLR(req[5]), .BIT_TEST(req[6]), .BIT_IDX(addr[4:0]),
		.BIT_SEL(bsel), .WDATA(wdata), .FLAG_EVENT(ev), .RDATA(rdata), .RD_VALID(),
		.BIT_VALUE(bit_value), .BIT_VALID(), .ADDR_MISS());
	iosd_core_model core_u (.clk_sys(clk_sys), .rdata(rdata), .bit_value(bit_value),
		.req(req), .addr(addr), .wdata(wdata), .bsel(bsel));
	function automatic [7:0] w1c(input [7:0] cur, input [7:0] w);
		w1c = cur & ~w;
	endfunction
	function automatic [7:0] put(input [7:0] cur, input [2:0] n, input b);
		put = b ? cur | (8'h01 << n) : cur & ~(8'h01 << n);
	endfunction
	task rd(input [2:0] k, input [7:0] a, input [7:0] e);
		begin
			core_u.op(k, a, 8'h00, 3'h0);
			`CHK(core_u.got, e)
		end
	endtask
	task pulse(input [7:0] p);
		begin
			ev = p;
			@(posedge clk_sys) #1;
			ev = 8'h00;
		end
	endtask
	task summarize;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, n_fail);
			if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
			else $display("Finished with errors");
			$finish;
		end
	endtask
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		#200000;
		n_fail++;
		summarize;
	end
	initial begin
		v = $urandom(19063);
		repeat (6) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		rd(0, `IOSD_ADDR_SCR1, 8'h00);
		rd(0, `IOSD_ADDR_SCR0, 8'h00);
		rd(2, 8'h00, 8'h00); // unmapped places read as zero
		rd(0, 8'h20, 8'h00);
		$display("reset test done");
		for (i = 0; i < 16; i++) begin
			v = (i == 0) ? 8'hff : $urandom;
			core_u.op(1, `IOSD_ADDR_SCR1, v, 3'h0);
			rd(0, `IOSD_ADDR_SCR1, v);
			rd(2, 8'h2a, v);
			core_u.op(3, 8'h2b, ~v, 3'h0);
			rd(0, `IOSD_ADDR_SCR2, ~v);
		end
		$display("scratch test done");
		core_u.op(1, `IOSD_ADDR_SCR1, 8'ha5, 3'h0);
		rst_n = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		rd(0, `IOSD_ADDR_SCR1, 8'h00);
		rd(2, 8'h2b, 8'h00);
		$display("mid-run reset test done");
		v = $urandom;
		core_u.op(3, 8'h1e, v, 3'h0);
		for (i = 0; i < 8; i++) begin
			core_u.op(6, 8'h1e, 8'h00, i);
			`CHK(core_u.got, {7'h00, v[i]})
			m = $urandom;
			core_u.op(m[0] ? 3'h4 : 3'h5, 8'h1e, 8'h00, i);
			v = put(v, i, m[0]);
		end
		rd(0, `IOSD_ADDR_SCR0, v);
		$display("bit test done");
		m = $urandom;
		core_u.op(1, `IOSD_ADDR_FLAGEN, m, 3'h0);
		rd(0, `IOSD_ADDR_FLAGEN, m);
		v = $urandom;
		pulse(v);
		f = v & m;
		rd(0, `IOSD_ADDR_FLAGS, f);
		v = $urandom;
		core_u.op(1, `IOSD_ADDR_FLAGS, v, 3'h0);
		f = w1c(f, v);
		rd(2, 8'h16, f);
		pulse(8'hff);
		f = f | m;
		core_u.op(5, 8'h16, 8'h00, 3'h2);
		core_u.op(4, 8'h16, 8'h00, 3'h5);
		f = w1c(f, 8'h20);
		rd(0, `IOSD_ADDR_FLAGS, f);
		ev = 8'hff;
		core_u.op(1, `IOSD_ADDR_FLAGS, 8'hff, 3'h0);
		ev = 8'h00;
		rd(0, `IOSD_ADDR_FLAGS, m);
		$display("flag test done");
		summarize;
	end
endmodule

// ===== core/iosd_defines.vh
// constants for the io space access decoder
// What this block does
// - every io location is reachable by load and store to its data-space address
// - short-form in and out use a 64-entry index mapped at index plus 0x20
// - bit set and bit clear act only on io indices 0x00 to 0x1f
// - skip-if-bit tests read one chosen bit of a low-range register
// - extended range 0x60 to 0xff is reached by load and store only
// - status flags clear on a written one; a written zero leaves them alone
// - bit set and clear touch only the addressed bit, other flags survive
// - three plain scratch registers; those in the low range are bit-addressable
// - second scratch register is eight bits read-write, resets to zero
`ifndef IOSD_DEFINES_VH
`define IOSD_DEFINES_VH

// data-space addresses of implemented registers
`define IOSD_IO_BASE      8'h20
`define IOSD_ADDR_FLAGS   8'h36
`define IOSD_ADDR_SCR0    8'h3e
`define IOSD_ADDR_SCR1    8'h4a
`define IOSD_ADDR_SCR2    8'h4b
`define IOSD_ADDR_FLAGEN  8'h60

// reset values
`define IOSD_RST_SCR      8'h00
`define IOSD_RST_FLAGS    8'h00
`define IOSD_RST_FLAGEN   8'h00
`define IOSD_ZERO_BYTE    8'h00

// widths
`define IOSD_DW           8
`define IOSD_AW           8
`define IOSD_IOW          6
`define IOSD_BITW         5

`endif

// ===== core/iosd_io_space.v
// io space access decoder with scratch, status flag and flag enable registers
`timescale 1ns/10ps
`include "iosd_defines.vh"

module iosd_io_space (
	input  wire       CLK_SYS,        // core clock
	input  wire       RST_N,          // async reset, active low
	input  wire       LDST_RD,        // load from data address
	input  wire       LDST_WR,        // store to data address
	input  wire [7:0] LDST_ADDR,      // data-space address
	input  wire       PORT_RD,        // short-form port input
	input  wire       PORT_WR,        // short-form port output
	input  wire [5:0] PORT_IDX,       // short-form io index
	input  wire       BIT_SET,        // bit set instruction
	input  wire       BIT_CLR,        // bit clear instruction
	input  wire       BIT_TEST,       // skip-if-bit test
	input  wire [4:0] BIT_IDX,        // low-range io index
	input  wire [2:0] BIT_SEL,        // bit number
	input  wire [7:0] WDATA,          // write data
	input  wire [7:0] FLAG_EVENT,     // status events, same clock
	output reg  [7:0] RDATA,          // read data
	output reg        RD_VALID,       // read data valid pulse
	output reg        BIT_VALUE,      // tested bit value
	output reg        BIT_VALID,      // tested bit valid pulse
	output reg        ADDR_MISS       // access in the previous cycle hit nothing
);

	// ****************************************
	// request decode
	// ****************************************
	reg  [7:0] scr0;
	reg  [7:0] scr1;
	reg  [7:0] scr2;
	reg  [7:0] flags;
	reg  [7:0] flag_en;

	// request kinds
	wire       ls_req   = LDST_RD | LDST_WR;
	wire       port_req = PORT_RD | PORT_WR;
	wire       bit_req  = BIT_SET | BIT_CLR | BIT_TEST;

	// port index is only six bits wide, so it can never land in the extended range
	wire [7:0] port_addr = {2'b00, PORT_IDX} + `IOSD_IO_BASE;
	// bit index is only five bits wide, limiting bit ops to the low range
	wire [7:0] bit_addr  = {3'b000, BIT_IDX} + `IOSD_IO_BASE;

	// load/store first, then port, then bit ops
	// a lower request in the same cycle is dropped, not queued
	reg  [7:0] acc_addr;
	reg        acc_rd;
	reg        acc_wr;
	reg        acc_bset;
	reg        acc_bclr;
	reg        acc_btest;
	always @* begin
		acc_addr  = `IOSD_ZERO_BYTE;
		acc_rd    = 1'b0;
		acc_wr    = 1'b0;
		acc_bset  = 1'b0;
		acc_bclr  = 1'b0;
		acc_btest = 1'b0;
		if (ls_req) begin
			acc_addr = LDST_ADDR;
			acc_rd   = LDST_RD;
			acc_wr   = LDST_WR;
		end else if (port_req) begin
			acc_addr = port_addr;
			acc_rd   = PORT_RD;
			acc_wr   = PORT_WR;
		end else if (bit_req) begin
			acc_addr  = bit_addr;
			acc_bset  = BIT_SET;
			acc_bclr  = BIT_CLR;
			acc_btest = BIT_TEST;
		end
	end

	// one compare per implemented register
	wire hit_scr0   = (acc_addr == `IOSD_ADDR_SCR0);
	wire hit_scr1   = (acc_addr == `IOSD_ADDR_SCR1);
	wire hit_scr2   = (acc_addr == `IOSD_ADDR_SCR2);
	wire hit_flags  = (acc_addr == `IOSD_ADDR_FLAGS);
	wire hit_flagen = (acc_addr == `IOSD_ADDR_FLAGEN);
	wire hit_any    = hit_scr0 | hit_scr1 | hit_scr2 | hit_flags | hit_flagen;
	wire any_acc    = acc_rd | acc_wr | acc_bset | acc_bclr | acc_btest;

	// ****************************************
	// read path
	// ****************************************
	// anything not decoded falls through to zero
	reg  [7:0] rd_mux;
	always @* begin
		rd_mux = `IOSD_ZERO_BYTE;
		if (hit_scr0)
			rd_mux = scr0;
		else if (hit_scr1)
			rd_mux = scr1;
		else if (hit_scr2)
			rd_mux = scr2;
		else if (hit_flags)
			rd_mux = flags;
		else if (hit_flagen)
			rd_mux = flag_en;
	end

	// ****************************************
	// write data forming
	// ****************************************
	// one-hot mask of the selected bit
	wire [7:0] bit_mask  = 8'h01 << BIT_SEL;
	wire       bit_op    = acc_bset | acc_bclr;
	// plain register value after a byte write
	wire [7:0] set_val   = WDATA;
	// scratch next value, other bits kept on bit ops
	function [7:0] scr_next;
		input [7:0] cur;
		begin
			if (acc_bset)
				scr_next = cur | bit_mask;
			else if (acc_bclr)
				scr_next = cur & ~bit_mask;
			else
				scr_next = set_val;
		end
	endfunction

	// ones that clear flags: byte write uses data, bit set only its own bit
	wire [7:0] flag_clr = (hit_flags & acc_wr)   ? WDATA    :
	                      (hit_flags & acc_bset) ? bit_mask :
	                      `IOSD_ZERO_BYTE;

	// ****************************************
	// write enables and next values
	// ****************************************
	wire       we_scr0   = hit_scr0 & (acc_wr | bit_op);
	wire       we_scr1   = hit_scr1 & acc_wr;
	wire       we_scr2   = hit_scr2 & acc_wr;
	wire       we_flagen = hit_flagen & acc_wr;
	reg  [7:0] next_scr0;
	reg  [7:0] next_scr1;
	reg  [7:0] next_scr2;
	reg  [7:0] next_flag_en;
	always @* begin
		next_scr0    = scr0;
		next_scr1    = scr1;
		next_scr2    = scr2;
		next_flag_en = flag_en;
		// of the scratch and enable registers only scr0 sits low enough for bit ops
		if (we_scr0)
			next_scr0 = scr_next(scr0);
		// scr1 and scr2 take whole bytes only
		if (we_scr1)
			next_scr1 = WDATA;
		if (we_scr2)
			next_scr2 = WDATA;
		// enable sits in the extended range, load/store only
		if (we_flagen)
			next_flag_en = WDATA;
	end

	// ****************************************
	// scratch and enable registers
	// ****************************************
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			scr0    <= `IOSD_RST_SCR;
			scr1    <= `IOSD_RST_SCR;
			scr2    <= `IOSD_RST_SCR;
			flag_en <= `IOSD_RST_FLAGEN;
		end else begin
			scr0    <= next_scr0;
			scr1    <= next_scr1;
			scr2    <= next_scr2;
			flag_en <= next_flag_en;
		end
	end

	// ****************************************
	// status flags, set wins over clear
	// ****************************************
	wire [7:0] flag_set = FLAG_EVENT & flag_en;
	wire [7:0] next_flags;
	genvar gi;
	generate
		for (gi = 0; gi < `IOSD_DW; gi = gi + 1) begin : g_flag
			// an event in the clearing cycle must not be lost
			assign next_flags[gi] = flag_set[gi] | (flags[gi] & ~flag_clr[gi]);
		end
	endgenerate

	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			flags <= `IOSD_RST_FLAGS;
		end else begin
			flags <= next_flags;
		end
	end

	// ****************************************
	// answers
	// ****************************************
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			RDATA     <= `IOSD_ZERO_BYTE;
			RD_VALID  <= 1'b0;
			BIT_VALUE <= 1'b0;
			BIT_VALID <= 1'b0;
			ADDR_MISS <= 1'b0;
		end else begin
			// strobes stand one cycle, data holds until the next read or test
			RD_VALID  <= acc_rd;
			BIT_VALID <= acc_btest;
			ADDR_MISS <= any_acc & ~hit_any;
			if (acc_rd)
				RDATA <= rd_mux;
			if (acc_btest)
				BIT_VALUE <= rd_mux[BIT_SEL];
		end
	end

endmodule
